//--- sim/dmaes_route_sva.sv
// assertion checker on the dma event selector ports
`timescale 1ns/1ps
module dmaes_route_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // apb slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // dma channel triggers
   input wire logic [15:0] channel_trigger
);
   // setup cycle seen while the slave is idle
   logic setup;
   assign setup = psel && !penable && !pready;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   answer_one_a: assert property (setup |=> pready)
      else $error("setup without answer");
   pulse_one_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_pair_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   hole_err_a: assert property (
      setup && paddr == 12'h008 |=> pslverr)
      else $error("hole not refused");
   map_ok_a: assert property (
      setup && paddr inside {12'h000, 12'h004, 12'h00C} |=> !pslverr)
      else $error("mapped word refused");
   rsvd_zero_a: assert property ((prdata & 32'hC0C0C0C0) == 32'h0)
      else $error("reserved gap not zero");
   idle_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   chain_quiet_a: assert property (channel_trigger[11:8] == 4'h0)
      else $error("chained channel fired");
endmodule
bind dmaes_route dmaes_route_sva dmaes_route_sva_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .channel_trigger(channel_trigger)
);

//--- sim/dmaes_route_tb.sv
// self-checking bench for the dma event selector
`timescale 1ns/1ps
module dmaes_route_tb;
   import dmaes_pkg::*;
   // bench-driven inputs, set at time zero
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [15:0] fire = 16'h0000;
   // design outputs and captured answers
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [15:0] src, channel_trigger;
   int mismatches = 0;
   int checked = 0;
   always #12.5 clk_sys = ~clk_sys;
   dmaes_src_model dmaes_src_model_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire), .events(src));
   dmaes_route dmaes_route_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .host_port_event(src[0]), .timer_zero_event(src[1]),
      .timer_one_event(src[2]), .mem_if_event(src[3]),
      .gpio_pin_event(src[7:4]), .gpio_pin2_event(src[10]),
      .serial0_tx_event(src[12]), .serial0_rx_event(src[13]),
      .serial1_tx_event(src[14]), .serial1_rx_event(src[15]),
      .channel_trigger(channel_trigger));
   task chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task stop_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one apb transfer; waits for pready under a bound
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <=
         {2'b10, w, a, d, (w ? s : 4'h0)}; // no strobes on reads
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 9) begin
         @(posedge clk_sys);
         n++;
      end
      if (pready !== 1'b1) begin
         chk("pready wait", {31'h0, pready}, 32'h1);
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // one-cycle source pulse; trigger one clock later, one cycle wide
   task pulse(input logic [15:0] v, e);
      @(posedge clk_sys);
      fire <= v;
      @(posedge clk_sys);
      fire <= 16'h0000;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("trigger", channel_trigger, e);
      @(negedge clk_sys);
      chk("trigger end", channel_trigger, 16'h0000);
   endtask
   task t_reset;
      apb(1'b1, 12'h008, 32'hFFFFFFFF, 4'hF);
      chk("hole write", err, 1'b1);
      apb(1'b0, DMAES_OFF_LOW, 32'h0, 4'hF);
      chk("low", rd, 32'h03020100);
      apb(1'b0, DMAES_OFF_MID, 32'h0, 4'hF);
      chk("mid", rd, 32'h07060504);
      apb(1'b0, DMAES_OFF_HIGH, 32'h0, 4'hF);
      chk("high", rd, 32'h0F0E0D0C);
      apb(1'b0, 12'h008, 32'h0, 4'hF);
      chk("hole", err, 1'b1);
      $display("reset test done");
   endtask
   task t_regs;
      apb(1'b1, DMAES_OFF_LOW, 32'hFFFFFFFF, 4'hF);
      apb(1'b0, DMAES_OFF_LOW, 32'h0, 4'hF);
      chk("low rw", rd, 32'h3F3F3F3F);
      apb(1'b1, DMAES_OFF_MID, 32'hFFFFFFFF, 4'h2);
      apb(1'b0, DMAES_OFF_MID, 32'h0, 4'hF);
      chk("mid byte", rd, 32'h07063F04);
      apb(1'b1, DMAES_OFF_LOW, 32'h03020100, 4'hF);
      apb(1'b1, DMAES_OFF_MID, 32'h07060504, 4'hF);
      $display("register test done");
   endtask
   // source codes 0-15 on channel fifteen; reserved codes stay quiet
   task t_route;
      logic [15:0] e;
      pulse(16'hFFFF, 16'hF0FF);
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, DMAES_OFF_HIGH, {2'b00, 6'(c), 24'h0E0D0C}, 4'hF);
         e = (c inside {[8:11]}) ? 16'h0000 : 16'h0001 << c;
         if (!(c inside {8, 9, 11})) e = e | 16'h8000;
         pulse(16'h0001 << c, e);
      end
      apb(1'b1, DMAES_OFF_HIGH, {2'b00, 6'h21, 24'h0E0D0C}, 4'hF);
      pulse(16'hFFFF, 16'h70FF);
      apb(1'b1, DMAES_OFF_HIGH, 32'h0F0E0D0C, 4'hF);
      $display("routing test done");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_regs();
      t_route();
      stop_test();
   end
endmodule

//--- sim/dmaes_src_model.sv
// peripheral event source model: request in, pulses of the same length out one cycle later
`timescale 1ns/1ps
module dmaes_src_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // bench request, indexed by selector code
   input wire logic [15:0] fire,
   // event pulses launched from a flop, like a real peripheral
   output logic [15:0] events
);
   // pulse lasts exactly as long as the request
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         events <= 16'h0000;
      end else begin
         events <= fire;
      end
   end
endmodule

//--- src/dmaes_event_pick.sv
// one channel's event multiplexer: code in, selected event out
`timescale 1ns/1ps
module dmaes_event_pick (
   // selection
   input wire dmaes_pkg::dmaes_code_t code,
   // event sources indexed by selector code
   input wire logic [dmaes_pkg::DMAES_NUM_SRC-1:0] events,
   // selected event
   output logic hit
);
   import dmaes_pkg::*;

   // codes 16 and up select nothing; reserved low codes come in as zero
   always_comb begin
      if (code[5:4] == 2'h0) begin
         hit = events[code[3:0]];
      end else begin
         hit = 1'b0;
      end
   end
endmodule

//--- src/dmaes_pkg.sv
// constants and types shared by the dma event selector files
package dmaes_pkg;
   // channel and field geometry
   localparam int unsigned DMAES_NUM_CHAN = 16;
   localparam int unsigned DMAES_NUM_SLOT = 12;
   localparam int unsigned DMAES_SLOTS_PER_WORD = 4;
   localparam int unsigned DMAES_CODE_W = 6;
   localparam int unsigned DMAES_FIELD_STRIDE = 8;
   localparam int unsigned DMAES_NUM_SRC = 16;
   // channels 8..11 are chained only and have no selector field
   localparam int unsigned DMAES_CHAIN_FIRST = 8;
   localparam int unsigned DMAES_CHAIN_GAP = 4;
   // register map, byte addresses
   localparam int unsigned DMAES_ADDR_W = 12;
   localparam logic [11:0] DMAES_OFF_LOW = 12'h000;
   localparam logic [11:0] DMAES_OFF_MID = 12'h004;
   localparam logic [11:0] DMAES_OFF_HIGH = 12'h00C;
   localparam logic [1:0] DMAES_WORD_LOW = 2'h0;
   localparam logic [1:0] DMAES_WORD_MID = 2'h1;
   localparam logic [1:0] DMAES_WORD_HIGH = 2'h2;
   localparam logic [1:0] DMAES_WORD_NONE = 2'h3;
   // selector codes of the event sources
   localparam int unsigned DMAES_CODE_HOST = 0;
   localparam int unsigned DMAES_CODE_TIMER0 = 1;
   localparam int unsigned DMAES_CODE_TIMER1 = 2;
   localparam int unsigned DMAES_CODE_MEMIF = 3;
   localparam int unsigned DMAES_CODE_GPIO4 = 4;
   localparam int unsigned DMAES_CODE_GPIO2 = 10;
   localparam int unsigned DMAES_CODE_SER0_TX = 12;
   localparam int unsigned DMAES_CODE_SER0_RX = 13;
   localparam int unsigned DMAES_CODE_SER1_TX = 14;
   localparam int unsigned DMAES_CODE_SER1_RX = 15;
   localparam int unsigned DMAES_NUM_GPIO_HI = 4;
   // types
   typedef logic [5:0] dmaes_code_t;
   typedef enum logic [1:0] {
      DMAES_ST_IDLE = 2'b01,
      DMAES_ST_ANSWER = 2'b10
   } dmaes_apb_st_t;
endpackage

//--- src/dmaes_route.sv
// dma event selector: apb register bank and per-channel trigger routing
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - reserved two-bit gaps read zero, ignore writes
// - four six-bit code fields per word
// - fields number channels upward across words
// - software reads and writes every code field
// - selected source event triggers its channel
// - channel fifteen with timer-zero code follows timer
// - reset code of each field is channel number
// - codes four to seven are gpio pins 4-7
module dmaes_route (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dmaes_pkg::DMAES_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral event sources, one-cycle pulses
   input wire logic host_port_event,
   input wire logic timer_zero_event,
   input wire logic timer_one_event,
   input wire logic mem_if_event,
   input wire logic [dmaes_pkg::DMAES_NUM_GPIO_HI-1:0] gpio_pin_event,
   input wire logic gpio_pin2_event,
   input wire logic serial0_tx_event,
   input wire logic serial0_rx_event,
   input wire logic serial1_tx_event,
   input wire logic serial1_rx_event,
   // enhanced_dma channel triggers
   output logic [dmaes_pkg::DMAES_NUM_CHAN-1:0] channel_trigger
);
   import dmaes_pkg::*;

   // register map: three selector words at byte offsets low, mid, high;
   // the gap between mid and high belongs to the chained channels and
   // answers with an error so that a stray access is noticed by software
   //
   // bus timing: the setup cycle is taken while idle and the answer is
   // registered, so pready rises in the access cycle and falls after it;
   // the slave never stretches a transfer, so a master sees no wait state
   //
   // trade-off: registering prdata costs a flop per bit but keeps the
   // read path off the address decoder at the edge that ends the access

   // storage holds twelve fields only: the four chained channels have
   // no selector, so slots above the gap are shifted past it
   // channel served by a storage slot
   function automatic int unsigned chan_of_slot(input int unsigned s);
      chan_of_slot = (s < DMAES_CHAIN_FIRST) ? s : s + DMAES_CHAIN_GAP;
   endfunction

   // which selector word an address hits
   function automatic logic [1:0] word_of_addr(
      input logic [DMAES_ADDR_W-1:0] a);
      unique case (a)
         DMAES_OFF_LOW: word_of_addr = DMAES_WORD_LOW;
         DMAES_OFF_MID: word_of_addr = DMAES_WORD_MID;
         DMAES_OFF_HIGH: word_of_addr = DMAES_WORD_HIGH;
         default: word_of_addr = DMAES_WORD_NONE;
      endcase
   endfunction

   dmaes_code_t code_ff [DMAES_NUM_SLOT]; // channel_event_code fields
   dmaes_code_t nxt_code [DMAES_NUM_SLOT];
   // bus state: idle waits for a setup cycle, answer is the access cycle
   dmaes_apb_st_t state_ff; // bus answer state
   dmaes_apb_st_t nxt_state;
   // registered bus outputs
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [31:0] rd_word; // assembled read value
   logic [1:0] word_sel; // decoded word
   logic [DMAES_NUM_SRC-1:0] src_vec; // events by selector code
   logic [DMAES_NUM_CHAN-1:0] hit; // selected event per channel
   logic [DMAES_NUM_CHAN-1:0] trig_ff;

   // decoded once and shared by the read path and the write path
   assign word_sel = word_of_addr(paddr);

   // a source appears once in the vector, so any number of channels
   // may pick it and all of them fire in the same cycle
   // gather sources by code; 8, 9, 11 are reserved and stay low
   always_comb begin
      src_vec = '0;
      src_vec[DMAES_CODE_HOST] = host_port_event;
      src_vec[DMAES_CODE_TIMER0] = timer_zero_event;
      src_vec[DMAES_CODE_TIMER1] = timer_one_event;
      src_vec[DMAES_CODE_MEMIF] = mem_if_event;
      for (int g = 0; g < DMAES_NUM_GPIO_HI; g++) begin
         src_vec[DMAES_CODE_GPIO4 + g] = gpio_pin_event[g];
      end
      src_vec[DMAES_CODE_GPIO2] = gpio_pin2_event;
      src_vec[DMAES_CODE_SER0_TX] = serial0_tx_event;
      src_vec[DMAES_CODE_SER0_RX] = serial0_rx_event;
      src_vec[DMAES_CODE_SER1_TX] = serial1_tx_event;
      src_vec[DMAES_CODE_SER1_RX] = serial1_rx_event;
   end

   // unmapped address reads as zero
   // read word: fields in low bits of each byte, gaps zero
   always_comb begin
      int unsigned s;
      rd_word = '0;
      s = 0;
      if (word_sel != DMAES_WORD_NONE) begin
         for (int j = 0; j < DMAES_SLOTS_PER_WORD; j++) begin
            s = int'(word_sel) * DMAES_SLOTS_PER_WORD + j;
            rd_word[j*DMAES_FIELD_STRIDE +: DMAES_CODE_W] = code_ff[s];
         end
      end
   end

   // bus answer and field writes
   // a write lands only at the edge that ends the access cycle; if the
   // master drops psel early the write is lost rather than half applied
   // bytes with a clear strobe keep their old field
   always_comb begin
      int unsigned s;
      s = 0;
      nxt_code = code_ff;
      nxt_state = state_ff;
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = prdata_ff;
      unique case (state_ff)
         DMAES_ST_IDLE: begin
            // setup phase: prepare the answer for the access cycle
            if (psel && !penable) begin
               nxt_state = DMAES_ST_ANSWER;
               nxt_pready = 1'b1;
               // unmapped address: error now, write ignored later
               nxt_pslverr = (word_sel == DMAES_WORD_NONE);
               nxt_prdata = pwrite ? 32'h0000_0000 : rd_word;
            end
         end
         DMAES_ST_ANSWER: begin
            // access completes at this edge; write lands here only
            nxt_state = DMAES_ST_IDLE;
            nxt_prdata = 32'h0000_0000;
            if (psel && penable && pwrite &&
                word_sel != DMAES_WORD_NONE) begin
               for (int j = 0; j < DMAES_SLOTS_PER_WORD; j++) begin
                  s = int'(word_sel) * DMAES_SLOTS_PER_WORD + j;
                  // only the six code bits are stored; gaps dropped
                  if (pstrb[j]) begin
                     nxt_code[s] =
                        pwdata[j*DMAES_FIELD_STRIDE +: DMAES_CODE_W];
                  end
               end
            end
         end
      endcase
   end

   // register stage for bus and fields
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // bus idle, no answer pending
         state_ff <= DMAES_ST_IDLE;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         for (int s = 0; s < DMAES_NUM_SLOT; s++) begin
            code_ff[s] <= dmaes_code_t'(chan_of_slot(s));
         end
      end else begin
         // plain copy of the next values
         state_ff <= nxt_state;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
         code_ff <= nxt_code;
      end
   end

   // per-channel multiplexers; chained channels have no selector
   for (genvar c = 0; c < DMAES_NUM_CHAN; c++) begin : g_chan
      if (c >= DMAES_CHAIN_FIRST &&
          c < DMAES_CHAIN_FIRST + DMAES_CHAIN_GAP) begin : g_chain
         assign hit[c] = 1'b0;
      end else begin : g_pick
         // slot of this channel, skipping the chained gap
         localparam int unsigned SLOT =
            (c < DMAES_CHAIN_FIRST) ? c : c - DMAES_CHAIN_GAP;
         dmaes_event_pick u_pick (
            .code(code_ff[SLOT]),
            .events(src_vec),
            .hit(hit[c])
         );
      end
   end

   // limitation: a source held high for several cycles gives a trigger
   // of the same length; the controller is expected to count edges
   // one cycle of latency keeps outputs registered; pulse width kept
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // no trigger may leak out of reset
         trig_ff <= '0;
      end else begin
         trig_ff <= hit;
      end
   end

   // outputs straight from their flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign channel_trigger = trig_ff;
endmodule
